/* design/codec_pkg.sv */
/*
 Shared constants, field layouts and carriers of the conditional-invert,
 master-transition line codec. Assumes one word-rate clock for both ends.
*/
package codec_pkg;

    // ==================================================================
    // Word layout
    localparam int CODE_W    = 20;   // Whole code word
    localparam int PAYLOAD_W = 16;   // w0..w15
    localparam int CTRL_W    = 14;   // Carried control bits
    localparam int CF_POS    = 16;   // c0 sits at this bit, c3 at 19
    localparam int MID_POS   = 7;    // w7 at bit 7, w8 at bit 8
    localparam int ACC_W     = 8;    // Running disparity accumulator
    localparam int DISP_W    = 6;    // Disparity of one word
    localparam int SCR_W     = 7;    // Scrambler state length

    // ==================================================================
    // Coding fields, written c0 c1 c2 c3 from left to right
    localparam logic [3:0] CF_DATA_F0 = 4'hd;  // 1101
    localparam logic [3:0] CF_DATA_F1 = 4'hb;  // 1011
    localparam logic [3:0] CF_CTRL_F0 = 4'h3;  // 0011
    localparam logic [3:0] CF_CTRL_F1 = 4'h5;  // 0101
    localparam logic [3:0] CF_IDLE_F0 = CF_CTRL_F0;
    localparam logic [3:0] CF_IDLE_F1 = CF_CTRL_F1;

    // ==================================================================
    // Payload constants, middle pair given as {w8,w7}
    localparam logic [1:0] MID_CTRL_TRUE = 2'h2;  // w7=0 w8=1
    localparam logic [1:0] MID_IDLE_A    = 2'h3;  // w7=1 w8=1
    localparam logic [1:0] MID_IDLE_B    = 2'h0;  // w7=0 w8=0
    localparam logic [6:0] IDLE_LOW      = 7'h7f; // w0..w6
    localparam logic [6:0] IDLE_HIGH     = 7'h00; // w9..w15

    // ==================================================================
    // Reset values
    localparam logic signed [ACC_W-1:0] ACC_RESET = 8'sh00;
    localparam logic [SCR_W-1:0]        SCR_RESET = 7'h00;

    // Host request for one word period
    typedef struct packed {
        logic [PAYLOAD_W-1:0] data;
        logic                 data_word_select;
        logic                 control_word_select;
        logic                 user_flag_in;
        logic                 user_flag_enable;
    } tx_req_t;

    // Receive indications for one decoded word
    typedef struct packed {
        logic data_word_detected;
        logic control_word_detected;
        logic word_error_flag;
        logic flag;
    } rx_ind_t;

    // Turns c0..c3 order into bit order of the word and back
    function automatic logic [3:0] cf_order(input logic [3:0] cf);
        cf_order = {cf[0], cf[1], cf[2], cf[3]};
    endfunction

endpackage

/* design/word_disparity.sv */
/*
 Disparity of one code word, zeros minus ones, and its sign.
 Assumes a combinational path is acceptable at the word rate.
*/
`timescale 1ns/1ps

module word_disparity
    import codec_pkg::*;
#(
    parameter int W = CODE_W
) (
    input  wire logic [W-1:0]              word,
    output logic signed [DISP_W-1:0]       disp,
    output logic                           sign
);

    logic [DISP_W-1:0] ones;

    // Population count of the word
    always_comb begin
        ones = '0;
        for (int i = 0; i < W; i++) begin
            ones = ones + DISP_W'(word[i]);
        end
    end

    // Zeros minus ones; sign high when ones dominate
    assign disp = DISP_W'(W) - {ones[DISP_W-2:0], 1'b0};
    assign sign = disp[DISP_W-1];

endmodule // word_disparity

/* design/bit_scrambler.sv */
/*
 Self-synchronising single-bit scrambler, polynomial x^7 + x^6 + 1.
 Assumes both link ends advance on the same kinds of words.
*/
`timescale 1ns/1ps

module bit_scrambler
    import codec_pkg::*;
(
    input  wire logic ref_clk,
    input  wire logic resetn,
    input  wire logic advance,
    input  wire logic descramble,
    input  wire logic bit_in,
    output logic      bit_out
);

    logic [SCR_W-1:0] state_q;
    logic [SCR_W-1:0] state_d;
    logic             line_bit;

    // Output mixes in two taps; the line bit feeds the history
    assign bit_out  = bit_in ^ state_q[SCR_W-1] ^ state_q[SCR_W-2];
    assign line_bit = descramble ? bit_in : bit_out;
    assign state_d  = {state_q[SCR_W-2:0], line_bit};

    // History of line bits
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= SCR_RESET;
        end else if (advance) begin
            state_q <= state_d;
        end
    end

endmodule // bit_scrambler

/* design/invert_master_transition_codec.sv */
/*
 Encoder and decoder of the 20-bit conditional-invert, master-transition
 line code, one word per ref_clk cycle on each side.
 Assumes host inputs and received words are synchronous to ref_clk and a
 serialiser outside sends tx_code_word from bit 0 upward.
*/
`timescale 1ns/1ps

module invert_master_transition_codec
    import codec_pkg::*;
(
    input  wire logic                 ref_clk,
    input  wire logic                 resetn,
    input  wire tx_req_t              tx_req,
    input  wire logic                 enhanced_simplex_enable,
    output logic [CODE_W-1:0]         tx_code_word,
    output logic                      running_disparity_sign,
    input  wire logic [CODE_W-1:0]    rx_code_word,
    output logic [PAYLOAD_W-1:0]      rx_data,
    output rx_ind_t                   rx_ind
);

    // ==================================================================
    // Transmit state
    logic signed [ACC_W-1:0]  acc_q;
    logic signed [ACC_W-1:0]  acc_d;
    logic                     odd_even_q;
    logic                     odd_even_d;
    logic [CODE_W-1:0]        tx_q;
    logic [CODE_W-1:0]        tx_true;
    logic [CODE_W-1:0]        tx_d;
    logic [PAYLOAD_W-1:0]     pay_true;
    logic [3:0]               cf_true;
    logic signed [DISP_W-1:0] disp_sent;
    logic                     word_sign;
    logic                     acc_sign;
    logic                     invert;
    logic                     flag_raw;
    logic                     flag_scr;
    logic                     flag_sent;
    logic                     w0_scr;
    logic                     w0_sent;
    logic                     w0_scr_on;
    logic                     esm;

    wire is_data = tx_req.data_word_select;
    wire is_ctrl = !tx_req.data_word_select && tx_req.control_word_select;
    wire is_idle = !tx_req.data_word_select && !tx_req.control_word_select;

    assign esm      = enhanced_simplex_enable;
    assign acc_sign = acc_q[ACC_W-1];

    // control and idle send flag 0 before scrambling
    assign flag_raw   = is_data ? (tx_req.user_flag_enable ? tx_req.user_flag_in : odd_even_q) : 1'b0;
    assign odd_even_d = (is_data && !tx_req.user_flag_enable) ? !odd_even_q : odd_even_q;

    // flag scrambled on the way out
    bit_scrambler u_flag_scr (
        .ref_clk    (ref_clk),
        .resetn     (resetn),
        .advance    (esm),
        .descramble (1'b0),
        .bit_in     (flag_raw),
        .bit_out    (flag_scr)
    );
    assign flag_sent = esm ? flag_scr : flag_raw;

    // w0 scrambled on data and control words
    assign w0_scr_on = esm && !is_idle;
    bit_scrambler u_w0_scr (
        .ref_clk    (ref_clk),
        .resetn     (resetn),
        .advance    (w0_scr_on),
        .descramble (1'b0),
        .bit_in     (tx_req.data[0]),
        .bit_out    (w0_scr)
    );
    assign w0_sent = w0_scr_on ? w0_scr : tx_req.data[0];

    // ==================================================================
    // Word field of the true form
    // data bits kept in place
    // control drops the top two bits
    // control bits split around the middle pair
    // middle pair forced in the true form
    // idle has rising edges only in the coding field
    assign pay_true = is_data ? {tx_req.data[PAYLOAD_W-1:1], w0_sent} :
                      is_ctrl ? {tx_req.data[CTRL_W-1:7], MID_CTRL_TRUE, tx_req.data[6:1], w0_sent} :
                      {IDLE_HIGH, (acc_sign ? MID_IDLE_B : MID_IDLE_A), IDLE_LOW};

    // c1 and c2 differ in every field
    assign cf_true = is_data ? (flag_sent ? CF_DATA_F1 : CF_DATA_F0) :
                     is_ctrl ? ((esm && flag_sent) ? CF_CTRL_F1 : CF_CTRL_F0) :
                     ((esm && flag_sent) ? CF_IDLE_F1 : CF_IDLE_F0);

    assign tx_true = {cf_order(cf_true), pay_true};

    word_disparity #(.W(CODE_W)) u_disp_true (
        .word (tx_true),
        .disp (),
        .sign (word_sign)
    );

    // invert when signs agree, never for idle
    // inverted control takes the full complement
    assign invert = !is_idle && (word_sign == acc_sign);
    assign tx_d   = invert ? ~tx_true : tx_true;

    word_disparity #(.W(CODE_W)) u_disp_sent (
        .word (tx_d),
        .disp (disp_sent),
        .sign ()
    );

    assign acc_d = acc_q + ACC_W'(disp_sent);

    // balanced at reset, updated each word
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            acc_q      <= ACC_RESET;
            odd_even_q <= 1'b0;
            tx_q       <= '0;
        end else begin
            acc_q      <= acc_d;
            odd_even_q <= odd_even_d;
            tx_q       <= tx_d;
        end
    end

    assign tx_code_word           = tx_q;
    assign running_disparity_sign = acc_sign;

    // ==================================================================
    // Receive classification
    logic [3:0]           rcf;
    logic [1:0]           rmid;
    logic                 r_data_t;
    logic                 r_data_i;
    logic                 r_ctrl_t;
    logic                 r_ctrl_i;
    logic                 r_idle;
    logic                 r_data;
    logic                 r_ctrl;
    logic                 r_err;
    logic                 r_inv;
    logic                 r_flag_line;
    logic                 r_flag_desc;
    logic                 r_flag;
    logic                 r_w0_on;
    logic                 r_w0_desc;
    logic                 r_w0;
    logic [PAYLOAD_W-1:0] r_pay;
    logic [PAYLOAD_W-1:0] rx_data_d;
    logic [PAYLOAD_W-1:0] rx_data_q;
    rx_ind_t              rx_ind_d;
    rx_ind_t              rx_ind_q;

    assign rcf  = cf_order(rx_code_word[CODE_W-1:CF_POS]);
    assign rmid = rx_code_word[MID_POS+1:MID_POS];

    // Field matches in both forms, idle in the true form only
    assign r_data_t = (rcf == CF_DATA_F0) || (rcf == CF_DATA_F1);
    assign r_data_i = (rcf == ~CF_DATA_F0) || (rcf == ~CF_DATA_F1);
    assign r_ctrl_t = ((rcf == CF_CTRL_F0) || (esm && rcf == CF_CTRL_F1)) && (rmid == MID_CTRL_TRUE);
    assign r_ctrl_i = ((rcf == ~CF_CTRL_F0) || (esm && rcf == ~CF_CTRL_F1)) && (rmid == ~MID_CTRL_TRUE);
    assign r_idle   = ((rcf == CF_IDLE_F0) || (esm && rcf == CF_IDLE_F1)) &&
                      ((rmid == MID_IDLE_A) || (rmid == MID_IDLE_B));

    // c1 equal c2 and every unmatched field are errors
    assign r_data = r_data_t || r_data_i;
    assign r_ctrl = r_ctrl_t || r_ctrl_i;
    assign r_err  = (rcf[2] == rcf[1]) || !(r_data || r_ctrl || r_idle);

    assign r_inv = r_data_i || r_ctrl_i;
    assign r_pay = r_inv ? ~rx_code_word[PAYLOAD_W-1:0] : rx_code_word[PAYLOAD_W-1:0];

    // Line flag as carried in the coding field
    assign r_flag_line = r_data ? ((rcf == CF_DATA_F1) || (rcf == ~CF_DATA_F1)) :
                         ((rcf == CF_CTRL_F1) || (rcf == ~CF_CTRL_F1));

    // flag descrambled on every good word
    bit_scrambler u_flag_desc (
        .ref_clk    (ref_clk),
        .resetn     (resetn),
        .advance    (esm && !r_err),
        .descramble (1'b1),
        .bit_in     (r_flag_line),
        .bit_out    (r_flag_desc)
    );
    assign r_flag = esm ? r_flag_desc : r_flag_line;

    // w0 descrambled on data and control words
    assign r_w0_on = esm && !r_err && (r_data || r_ctrl);
    bit_scrambler u_w0_desc (
        .ref_clk    (ref_clk),
        .resetn     (resetn),
        .advance    (r_w0_on),
        .descramble (1'b1),
        .bit_in     (r_pay[0]),
        .bit_out    (r_w0_desc)
    );
    assign r_w0 = r_w0_on ? r_w0_desc : r_pay[0];

    // control bits moved down to 0..13
    assign rx_data_d = (r_err || r_idle) ? '0 :
                       r_data ? {r_pay[PAYLOAD_W-1:1], r_w0} :
                       {2'h0, r_pay[PAYLOAD_W-1:MID_POS+2], r_pay[MID_POS-1:1], r_w0};

    // flag shown only for data words
    assign rx_ind_d.data_word_detected    = !r_err && r_data;
    assign rx_ind_d.control_word_detected = !r_err && r_ctrl;
    assign rx_ind_d.word_error_flag       = r_err;
    assign rx_ind_d.flag                  = !r_err && r_data && r_flag;

    // Registered receive outputs
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rx_data_q <= '0;
            rx_ind_q  <= '0;
        end else begin
            rx_data_q <= rx_data_d;
            rx_ind_q  <= rx_ind_d;
        end
    end

    assign rx_data = rx_data_q;
    assign rx_ind  = rx_ind_q;

    // ==================================================================
    // Checks
    property p_idle_default;
        @(posedge ref_clk) disable iff (!resetn)
        (!tx_req.data_word_select && !tx_req.control_word_select) |=>
            (tx_q[6:0] == IDLE_LOW) && (tx_q[PAYLOAD_W-1:9] == IDLE_HIGH);
    endproperty
    a_idle_default: assert property (p_idle_default) else $error("idle word not sent");

    property p_master_edge;
        @(posedge ref_clk) disable iff (!resetn)
        $past(resetn) |-> (tx_q[CF_POS+1] != tx_q[CF_POS+2]);
    endproperty
    a_master_edge: assert property (p_master_edge) else $error("no master transition");

    property p_balance;
        @(posedge ref_clk) disable iff (!resetn)
        (acc_q <= 8'sh28) && (acc_q >= -8'sh28);
    endproperty
    a_balance: assert property (p_balance) else $error("disparity out of range");

    property p_data_carry;
        @(posedge ref_clk) disable iff (!resetn)
        (tx_req.data_word_select && !esm) |=>
            (tx_q[PAYLOAD_W-1:0] == $past(tx_req.data)) || (tx_q[PAYLOAD_W-1:0] == ~$past(tx_req.data));
    endproperty
    a_data_carry: assert property (p_data_carry) else $error("data bits moved");

    property p_flag_toggle;
        @(posedge ref_clk) disable iff (!resetn)
        (tx_req.data_word_select && !tx_req.user_flag_enable) |=> (odd_even_q != $past(odd_even_q));
    endproperty
    a_flag_toggle: assert property (p_flag_toggle) else $error("flag did not alternate");

    property p_ctrl_mid;
        @(posedge ref_clk) disable iff (!resetn)
        (!tx_req.data_word_select && tx_req.control_word_select) |=>
            (tx_q[MID_POS+1:MID_POS] == (tx_q[CF_POS] ? ~MID_CTRL_TRUE : MID_CTRL_TRUE));
    endproperty
    a_ctrl_mid: assert property (p_ctrl_mid) else $error("control middle pair wrong");

    property p_idle_variant;
        @(posedge ref_clk) disable iff (!resetn)
        (is_idle && !acc_sign) |=> (tx_q[MID_POS+1:MID_POS] == MID_IDLE_A);
    endproperty
    a_idle_variant: assert property (p_idle_variant) else $error("wrong idle variant");

    property p_rx_c1c2;
        @(posedge ref_clk) disable iff (!resetn)
        resetn && (rx_code_word[CF_POS+1] == rx_code_word[CF_POS+2]) |=> rx_ind_q.word_error_flag;
    endproperty
    a_rx_c1c2: assert property (p_rx_c1c2) else $error("c1 equal c2 not flagged");

    property p_rx_flag_data;
        @(posedge ref_clk) disable iff (!resetn)
        !rx_ind_q.data_word_detected |-> !rx_ind_q.flag;
    endproperty
    a_rx_flag_data: assert property (p_rx_flag_data) else $error("flag shown on non-data word");

    property p_rx_one_kind;
        @(posedge ref_clk) disable iff (!resetn)
        $past(resetn) |-> $onehot0({rx_ind_q.data_word_detected, rx_ind_q.control_word_detected,
                                    rx_ind_q.word_error_flag});
    endproperty
    a_rx_one_kind: assert property (p_rx_one_kind) else $error("more than one word kind");

endmodule // invert_master_transition_codec

/* tb/far_end_encoder.sv */
/*
 Far-end transmitter model: plain-mode encoder of the line code, used as
 the word source of the receiver and as the reference of the sent words.
 Assumes the codec's word clock and asynchronous active-low reset.
*/
`timescale 1ns/1ps

module far_end_encoder
    import codec_pkg::*;
(
    input  wire logic         ref_clk,
    input  wire logic         resetn,
    input  wire tx_req_t      req,
    output logic [CODE_W-1:0] word
);

    // ==================================================================
    // Word assembly
    logic signed [ACC_W-1:0] acc_q;
    logic                    oe_q;
    logic                    flag;
    logic                    idle;
    logic                    inv;
    logic [CODE_W-1:0]       raw;
    logic signed [ACC_W-1:0] disp;

    assign flag = req.user_flag_enable ? req.user_flag_in : oe_q;
    assign idle = !req.data_word_select && !req.control_word_select;
    assign raw  = req.data_word_select ? {flag ? 4'hd : 4'hb, req.data}
                : (req.control_word_select ? {4'hc, req.data[13:7], 2'h2, req.data[6:0]}
                : {4'hc, 7'h00, acc_q[ACC_W-1] ? 2'h0 : 2'h3, 7'h7f});
    // Zeros minus ones of the true word
    assign disp = ACC_W'(CODE_W - 2 * $countones(raw));
    assign inv  = !idle && (disp[ACC_W-1] == acc_q[ACC_W-1]);

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            acc_q <= ACC_RESET;
            oe_q  <= 1'b0;
            word  <= '0;
        end else begin
            word  <= inv ? ~raw : raw;
            acc_q <= inv ? acc_q - disp : acc_q + disp;
            if (req.data_word_select && !req.user_flag_enable) begin
                oe_q <= !oe_q;
            end
        end
    end

endmodule // far_end_encoder

/* tb/tb_invert_master_transition_codec.sv */
/*
 Self-checking bench of the line codec: plain-mode words against a far-end
 encoder, decode through the link, a table of raw words, scrambled loopback.
 Assumes the codec package and the far-end model are compiled first.
*/
`timescale 1ns/1ps

module tb_invert_master_transition_codec
    import codec_pkg::*;
;

    // ==================================================================
    // Signals
    logic                 ref_clk = 1'b0;
    logic                 resetn = 1'b0;
    logic                 scr = 1'b0;
    logic                 scr_seen = 1'b0;
    logic                 raw_en = 1'b0;
    logic [CODE_W-1:0]    rx_raw = '0;
    tx_req_t              tx_req = '0;
    tx_req_t              hist1;
    tx_req_t              hist2;
    logic [CODE_W-1:0]    tx_code_word;
    logic [CODE_W-1:0]    far_word;
    logic [CODE_W-1:0]    rx_word;
    logic [PAYLOAD_W-1:0] rx_data;
    rx_ind_t              rx_ind;
    logic                 sign;
    logic [18:0]          rx_got;
    logic [18:0]          rx_exp;
    logic [3:0]           tx_cf;
    logic                 shape_ok;
    int                   warm = 0;
    int                   errors = 0;
    int                   checks_done = 0;

    // Raw received words: word, {data, control, error, flag}, data
    localparam logic [39:0] RAW_TABLE [15] = '{
        40'hb1234_8_1234, 40'h4edcb_8_1234, 40'hd1234_9_1234, 40'h2edcb_9_1234, 40'hc5555_4_1555,
        40'h3aaaa_4_1555, 40'hc01ff_0_0000, 40'hc007f_0_0000, 40'h91234_2_0000, 40'h61234_2_0000,
        40'h30000_2_0000, 40'h30180_2_0000, 40'h50000_2_0000, 40'ha0000_2_0000, 40'hc0080_2_0000
    };

    // Word clock, 5 ns period
    always #2.5 ref_clk = ~ref_clk;

    invert_master_transition_codec u_dut (
        .ref_clk                 (ref_clk),
        .resetn                  (resetn),
        .tx_req                  (tx_req),
        .enhanced_simplex_enable (scr),
        .tx_code_word            (tx_code_word),
        .running_disparity_sign  (sign),
        .rx_code_word            (rx_word),
        .rx_data                 (rx_data),
        .rx_ind                  (rx_ind)
    );

    far_end_encoder u_far (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .req     (tx_req),
        .word    (far_word)
    );

    // Link source: raw word, own words looped back, or far end
    assign rx_word  = raw_en ? rx_raw : (scr ? tx_code_word : far_word);
    assign rx_got   = {rx_ind.data_word_detected, rx_ind.control_word_detected, rx_ind.word_error_flag, rx_data};
    assign rx_exp   = {hist2.data_word_select, !hist2.data_word_select && hist2.control_word_select, 1'b0,
                       hist2.data_word_select ? hist2.data
                       : (hist2.control_word_select ? {2'h0, hist2.data[13:0]} : 16'h0000)};
    assign tx_cf    = tx_code_word[19:16];
    // Legal scrambled-mode shapes per word kind
    assign shape_ok = hist1.data_word_select ? (tx_cf == 4'hb || tx_cf == 4'h4 || tx_cf == 4'hd || tx_cf == 4'h2)
                    : (hist1.control_word_select
                       ? (((tx_cf == 4'hc || tx_cf == 4'ha) && tx_code_word[8:7] == 2'h2)
                          || ((tx_cf == 4'h3 || tx_cf == 4'h5) && tx_code_word[8:7] == 2'h1))
                       : ((tx_cf == 4'hc || tx_cf == 4'ha)
                          && (tx_code_word[15:0] == 16'h01ff || tx_code_word[15:0] == 16'h007f)));

    // ==================================================================
    // Helpers
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("ERROR at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask

    function automatic tx_req_t mk(logic [15:0] d, logic ds, logic cs, logic uf, logic ue);
        mk = '{data: d, data_word_select: ds, control_word_select: cs, user_flag_in: uf, user_flag_enable: ue};
    endfunction

    task automatic send(input tx_req_t r);
        @(posedge ref_clk);
        tx_req <= r;
    endtask

    task automatic flush();
        repeat (3) send('0);
    endtask

    task automatic check_raw(input logic [CODE_W-1:0] w, input logic [3:0] ind, input logic [15:0] d);
        @(posedge ref_clk);
        rx_raw <= w;
        raw_en <= 1'b1;
        @(posedge ref_clk);
        @(negedge ref_clk);
        chk({rx_ind, rx_data}, {ind, d});
    endtask

    // Requests as sampled by the codec, settling time after changes
    always @(posedge ref_clk) begin
        hist2    <= hist1;
        hist1    <= tx_req;
        scr_seen <= scr;
        warm     <= (!resetn || raw_en || scr != scr_seen) ? 0 : warm + 1;
    end

    // Every word on both sides is judged once settled
    always @(negedge ref_clk) begin
        if (resetn && !scr) begin
            chk(tx_code_word, far_word);
        end
        if (resetn && scr && warm > 0) begin
            chk(shape_ok, 1'b1);
        end
        if (resetn && !raw_en && warm > 11) begin
            chk(rx_got, rx_exp);
            if (hist2.user_flag_enable || !hist2.data_word_select) begin
                chk(rx_ind.flag, hist2.data_word_select && hist2.user_flag_in);
            end
        end
    end

    // ==================================================================
    // Scenarios
    task automatic do_reset();
        @(posedge ref_clk);
        resetn <= 1'b0;
        tx_req <= '0;
        repeat (11) @(posedge ref_clk);
        @(negedge ref_clk);
        chk({sign, tx_code_word}, 21'h0);
        @(posedge ref_clk);
        resetn <= 1'b1;
        @(posedge ref_clk);
        @(negedge ref_clk);
        chk({sign, tx_code_word}, {1'b1, 20'hc01ff});
        @(negedge ref_clk);
        chk({sign, tx_code_word}, {1'b0, 20'hc007f});
    endtask

    task automatic sc_data();
        for (int i = 0; i < 12; i++) begin
            send(mk(i == 1 ? 16'hffff : 16'(i * 16'h2f1d), 1'b1, i[0], i[1], i < 6));
        end
        flush();
    endtask

    task automatic sc_ctrl();
        for (int i = 0; i < 8; i++) begin
            send(mk(16'hc000 | 16'(i * 16'h0b3d), 1'b0, 1'b1, i[0], 1'b0));
        end
        flush();
    endtask

    task automatic sc_mix();
        for (int i = 0; i < 18; i++) begin
            send(mk(16'(i * 16'h4e6d), i % 3 == 0, i % 3 == 1, i[2], i[3]));
        end
    endtask

    task automatic sc_raw();
        for (int i = 0; i < 15; i++) begin
            check_raw(RAW_TABLE[i][39:20], RAW_TABLE[i][19:16], RAW_TABLE[i][15:0]);
        end
    endtask

    task automatic sc_scrambled();
        @(posedge ref_clk);
        raw_en <= 1'b0;
        scr    <= 1'b1;
        sc_mix();
        sc_mix();
        flush();
        check_raw(20'ha01ff, 4'h0, 16'h0000);
    endtask

    // ==================================================================
    // Verdict and run control
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Watchdog against a hang
    initial begin
        repeat (2000) @(posedge ref_clk);
        errors++;
        tally_and_finish();
    end

    // Main sequence, with a reset in mid-run
    initial begin
        do_reset();
        sc_data();
        sc_ctrl();
        sc_mix();
        flush();
        do_reset();
        sc_raw();
        sc_scrambled();
        tally_and_finish();
    end

endmodule // tb_invert_master_transition_codec
